// ===== hdl/fmd_top.v
// Global motion, film mode, film type and film phase detector.
// Assumes the motion estimator and register host run on CORE_CLK; field pulses are one cycle wide.
`timescale 1ns/1ns
`include "fmd_map.vh"

module fmd_top (
    input wire CORE_CLK,
    input wire ARST_N,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    input wire FIELD_START,
    input wire FIELD_END,
    input wire FIELD_B,
    input wire VEC_VALID,
    input wire [7:0] VEC_X,
    input wire [7:0] VEC_Y,
    input wire DIFF_VALID,
    input wire [7:0] DIFF_VALUE,
    output reg FILM_MODE,
    output reg FILM_PHASE,
    output reg FILM_TYPE,
    output reg GLOBAL_MOTION,
    output reg FIELD_MOTION
);

////////////////////////////////////////////////////////////////////////////////
// Helpers

function [7:0] abs8;
    input [7:0] v;
    begin
        if (v[7]) begin
            abs8 = (~v) + 8'h01;
        end else begin
            abs8 = v;
        end
    end
endfunction

// Whole component when above the minimum threshold, zero otherwise
function [7:0] over_min;
    input [7:0] mag;
    input [3:0] thr;
    begin
        if (mag > {4'h0, thr}) begin
            over_min = mag;
        end else begin
            over_min = 8'h00;
        end
    end
endfunction

// True when two neighbouring history bits are both set
function adj_ones;
    input [5:0] h;
    begin
        adj_ones = |(h[4:0] & h[5:1]);
    end
endfunction

// True when two neighbouring history bits are both clear
function adj_zeros;
    input [5:0] h;
    begin
        adj_zeros = |(~h[4:0] & ~h[5:1]);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Register file

reg [7:0] ctrl_a_reg;
reg [7:0] scale_reg;
reg [7:0] maxth_reg;
reg [7:0] hist_len_reg;
reg [7:0] src_reg;

wire phase_invert_ctrl;
wire [3:0] min_vector_threshold;
wire [1:0] lower_scale_select;
wire [1:0] upper_scale_select;
wire [7:0] camera_motion_threshold;
wire [7:0] film_motion_threshold;
wire [3:0] hysteresis_setting;
wire [3:0] detect_source_threshold;
wire [7:0] status_byte;

assign phase_invert_ctrl = ctrl_a_reg[`FMD_PHINV_BIT];
assign min_vector_threshold = ctrl_a_reg[`FMD_MINVEC_MSB:`FMD_MINVEC_LSB];
assign lower_scale_select = scale_reg[`FMD_LSCALE_MSB:`FMD_LSCALE_LSB];
assign upper_scale_select = scale_reg[`FMD_USCALE_MSB:`FMD_USCALE_LSB];
assign camera_motion_threshold = {4'h0, scale_reg[`FMD_CAMTH_MSB:`FMD_CAMTH_LSB]};
assign film_motion_threshold = {1'b0, maxth_reg[`FMD_FILMTH_MSB:`FMD_FILMTH_LSB]};
assign hysteresis_setting = hist_len_reg[`FMD_HYST_MSB:`FMD_HYST_LSB];
assign detect_source_threshold = src_reg[`FMD_SRCTH_MSB:`FMD_SRCTH_LSB];

always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        ctrl_a_reg <= `FMD_RST_CTRL_A;
        scale_reg <= `FMD_RST_SCALE;
        maxth_reg <= `FMD_RST_MAXTH;
        hist_len_reg <= `FMD_RST_HIST;
        src_reg <= `FMD_RST_SRC;
    end else if (REG_WR) begin
        case (REG_ADDR)
            `FMD_ADDR_CTRL_A: ctrl_a_reg <= REG_WDATA;
            `FMD_ADDR_SCALE: scale_reg <= REG_WDATA;
            `FMD_ADDR_MAXTH: maxth_reg <= REG_WDATA;
            `FMD_ADDR_HIST: hist_len_reg <= REG_WDATA;
            `FMD_ADDR_SRC: src_reg <= REG_WDATA;
            default: ctrl_a_reg <= ctrl_a_reg;
        endcase
    end
end

// Only the status register reads back; write-only and absent addresses read zero
always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
        if (REG_ADDR == `FMD_ADDR_STATUS) begin
            REG_RDATA <= status_byte;
        end else begin
            REG_RDATA <= 8'h00;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Activity accumulation

reg [21:0] vector_activity_reg;
reg [21:0] vector_activity_next;
reg [15:0] block_cnt_reg;
reg [15:0] block_cnt_next;

wire use_diff;
wire [7:0] comp_x;
wire [7:0] comp_y;
wire [8:0] vec_contrib;
wire [8:0] diff_contrib;
wire [8:0] contrib;
wire sample;
wire [22:0] acc_sum;

assign use_diff = detect_source_threshold != 4'h0;
assign comp_x = over_min(abs8(VEC_X), min_vector_threshold);
assign comp_y = over_min(abs8(VEC_Y), min_vector_threshold);
assign vec_contrib = {1'b0, comp_x} + {1'b0, comp_y};
assign diff_contrib = (DIFF_VALUE > {detect_source_threshold, 4'h0}) ? {1'b0, DIFF_VALUE} : 9'h000;
assign contrib = use_diff ? diff_contrib : vec_contrib;
assign sample = use_diff ? DIFF_VALID : VEC_VALID;

always @* begin
    vector_activity_next = vector_activity_reg;
    block_cnt_next = block_cnt_reg;
    if (FIELD_START) begin
        vector_activity_next = 22'h000000;
        block_cnt_next = 16'h0000;
    end
    if (sample && (contrib != 9'h000)) begin
        if (acc_sum[22]) begin
            vector_activity_next = 22'h3fffff;
        end else begin
            vector_activity_next = acc_sum[21:0];
        end
        if (block_cnt_next != 16'hffff) begin
            block_cnt_next = block_cnt_next + 16'h0001;
        end
    end
end

assign acc_sum = {1'b0, (FIELD_START ? 22'h000000 : vector_activity_reg)} + {14'h0000, contrib};

always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        vector_activity_reg <= 22'h000000;
        block_cnt_reg <= 16'h0000;
    end else begin
        vector_activity_reg <= vector_activity_next;
        block_cnt_reg <= block_cnt_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Field decision

wire above_lower;
wire above_upper;
wire motion;

fmd_scale_cmp u_lower (
    .sel(lower_scale_select),
    .thr(camera_motion_threshold),
    .value(vector_activity_reg),
    .above(above_lower)
);

fmd_scale_cmp u_upper (
    .sel(upper_scale_select),
    .thr(film_motion_threshold),
    .value(vector_activity_reg),
    .above(above_upper)
);

assign motion = above_upper | (above_lower & ~FILM_MODE);

////////////////////////////////////////////////////////////////////////////////
// Mode, type, phase and still tracking

reg [9:0] hist_reg;
reg [5:0] hyst_cnt_reg;
reg [5:0] still_cnt_reg;
reg phase_raw_reg;
reg [3:0] stat_reg;

wire [9:0] new_hist;
wire film_cond;
wire camera_cond;
wire switch_cond;
wire [5:0] hysteresis_field_count;
wire [5:0] hyst_cnt_inc;
wire [15:0] stat_shifted;

assign new_hist = {hist_reg[8:0], motion};
// Film cadence: no two moving fields in a row in the last six, some motion in the last three
assign film_cond = ~adj_ones(new_hist[5:0]) & (|new_hist[2:0]);
// Camera: two moving fields in a row
assign camera_cond = new_hist[0] & new_hist[1];
assign switch_cond = FILM_MODE ? camera_cond : film_cond;
assign hysteresis_field_count = {1'b0, hysteresis_setting, 1'b0} + 6'h02;
assign hyst_cnt_inc = hyst_cnt_reg + 6'h01;
assign stat_shifted = block_cnt_reg >> `FMD_STAT_SHIFT;

always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        hist_reg <= 10'h000;
        hyst_cnt_reg <= 6'h00;
        still_cnt_reg <= `FMD_STILL_FIELDS;
        phase_raw_reg <= 1'b0;
        stat_reg <= 4'h0;
        FILM_MODE <= 1'b0;
        FILM_TYPE <= 1'b0;
        GLOBAL_MOTION <= 1'b0;
        FIELD_MOTION <= 1'b0;
    end else if (FIELD_END) begin
        hist_reg <= new_hist;
        FIELD_MOTION <= motion;
        if (switch_cond) begin
            if (hyst_cnt_inc >= hysteresis_field_count) begin
                FILM_MODE <= ~FILM_MODE;
                hyst_cnt_reg <= 6'h00;
            end else begin
                hyst_cnt_reg <= hyst_cnt_inc;
            end
        end else begin
            hyst_cnt_reg <= 6'h00;
        end
        if (FILM_MODE) begin
            FILM_TYPE <= adj_zeros(new_hist[5:0]);
        end
        // Phase from parity of moving field
        if (FILM_MODE && motion) begin
            phase_raw_reg <= FIELD_B;
        end
        if (motion) begin
            still_cnt_reg <= 6'h00;
            GLOBAL_MOTION <= 1'b1;
        end else if (still_cnt_reg < `FMD_STILL_FIELDS) begin
            still_cnt_reg <= still_cnt_reg + 6'h01;
            GLOBAL_MOTION <= (still_cnt_reg + 6'h01) != `FMD_STILL_FIELDS;
        end
        if (stat_shifted > 16'h000f) begin
            stat_reg <= 4'hf;
        end else begin
            stat_reg <= stat_shifted[3:0];
        end
    end
end

always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
        FILM_PHASE <= 1'b0;
    end else begin
        FILM_PHASE <= phase_raw_reg ^ phase_invert_ctrl;
    end
end

assign status_byte = {FILM_MODE, FILM_PHASE, GLOBAL_MOTION, FILM_TYPE, stat_reg};

endmodule // fmd_top

// ===== hdl/fmd_map.vh
// Register map, field positions, reset values and fixed counts of the film mode detector.
// Assumes nothing of its surroundings; definitions only.
`ifndef FMD_MAP_VH
`define FMD_MAP_VH

// Register sub addresses
`define FMD_ADDR_CTRL_A 8'h4b
`define FMD_ADDR_SCALE 8'h4d
`define FMD_ADDR_MAXTH 8'h4e
`define FMD_ADDR_HIST 8'h4f
`define FMD_ADDR_SRC 8'h59
`define FMD_ADDR_STATUS 8'h7e

// Reset values of the writable registers
`define FMD_RST_CTRL_A 8'h00
`define FMD_RST_SCALE 8'h00
`define FMD_RST_MAXTH 8'h00
`define FMD_RST_HIST 8'h00
`define FMD_RST_SRC 8'h00

// film_detect_ctrl_a fields
`define FMD_PHINV_BIT 7
`define FMD_MINVEC_MSB 3
`define FMD_MINVEC_LSB 0

// film_threshold_scale fields
`define FMD_LSCALE_MSB 7
`define FMD_LSCALE_LSB 6
`define FMD_USCALE_MSB 5
`define FMD_USCALE_LSB 4
`define FMD_CAMTH_MSB 3
`define FMD_CAMTH_LSB 0

// film_max_threshold field
`define FMD_FILMTH_MSB 6
`define FMD_FILMTH_LSB 0

// film_history_length field
`define FMD_HYST_MSB 3
`define FMD_HYST_LSB 0

// film_source_select field
`define FMD_SRCTH_MSB 7
`define FMD_SRCTH_LSB 4

// film_detect_status fields
`define FMD_ST_FILM_BIT 7
`define FMD_ST_PHASE_BIT 6
`define FMD_ST_GMOT_BIT 5
`define FMD_ST_TYPE_BIT 4
`define FMD_ST_STAT_MSB 3
`define FMD_ST_STAT_LSB 0

// Scale factor multipliers for select codes 00..11
`define FMD_SCALE_0 8'h08
`define FMD_SCALE_1 8'h10
`define FMD_SCALE_2 8'h20
`define FMD_SCALE_3 8'h40

// Motionless fields needed to declare a still scene
`define FMD_STILL_FIELDS 6'h20
// Block count right shift for the motion statistic
`define FMD_STAT_SHIFT 4

`endif

// ===== hdl/fmd_scale_cmp.v
// Scaled threshold comparator: value > scale(sel) * (thr + 1).
// Assumes combinational use inside the detector core; no clock.
`timescale 1ns/1ns
`include "fmd_map.vh"

module fmd_scale_cmp (
    input wire [1:0] sel,
    input wire [7:0] thr,
    input wire [21:0] value,
    output wire above
);

reg [7:0] scale;
wire [8:0] thr_plus;
wire [16:0] limit;

always @* begin
    case (sel)
        2'b00: scale = `FMD_SCALE_0;
        2'b01: scale = `FMD_SCALE_1;
        2'b10: scale = `FMD_SCALE_2;
        2'b11: scale = `FMD_SCALE_3;
        default: scale = `FMD_SCALE_0;
    endcase
end

assign thr_plus = {1'b0, thr} + 9'h001;
assign limit = {9'h000, scale} * {8'h00, thr_plus};
assign above = value > {5'h00, limit};

endmodule // fmd_scale_cmp

// ===== tb/fmd_sva.sv
// Checker for fmd_top: read-back and field-rate timing of the outputs.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/1ns

module fmd_sva (
    input wire CORE_CLK,
    input wire ARST_N,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire [7:0] REG_RDATA,
    input wire FIELD_START,
    input wire FIELD_END,
    input wire FIELD_B,
    input wire VEC_VALID,
    input wire [7:0] VEC_X,
    input wire [7:0] VEC_Y,
    input wire DIFF_VALID,
    input wire [7:0] DIFF_VALUE,
    input wire FILM_MODE,
    input wire FILM_PHASE,
    input wire FILM_TYPE,
    input wire GLOBAL_MOTION,
    input wire FIELD_MOTION
);
    reg fe_d_reg;
    reg mode_d_reg;
    reg [5:0] still_reg;
    reg [3:0] evals_reg;

    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!ARST_N);

    ////////////////////////////////////////
    // Still fields in a row, and evaluations since the last mode swap
    always @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            fe_d_reg <= 1'b0;
            mode_d_reg <= 1'b0;
            still_reg <= 6'h20;
            evals_reg <= 4'h0;
        end else begin
            fe_d_reg <= FIELD_END;
            mode_d_reg <= FILM_MODE;
            if (fe_d_reg)
                still_reg <= FIELD_MOTION ? 6'h00 : still_reg + {5'h00, still_reg != 6'h20};
            if (FILM_MODE != mode_d_reg)
                evals_reg <= 4'h0;
            else if (FIELD_END && evals_reg != 4'hf)
                evals_reg <= evals_reg + 4'h1;
        end
    end

    sequence s_status_read;
        REG_RD && REG_ADDR == 8'h7e;
    endsequence

    AST_STATUS_BITS: assert property (s_status_read |=> REG_RDATA[7] == $past(FILM_MODE)
        && REG_RDATA[6] == $past(FILM_PHASE) && REG_RDATA[5] == $past(GLOBAL_MOTION)
        && REG_RDATA[4] == $past(FILM_TYPE)) else $error("status bits wrong");
    AST_RDATA_HOLD: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved");
    AST_GM_ON_MOTION: assert property (FIELD_MOTION |-> GLOBAL_MOTION)
        else $error("moving field without global motion");
    AST_GM_STILL: assert property (!fe_d_reg |-> GLOBAL_MOTION == (still_reg != 6'h20))
        else $error("global motion against still count");
    AST_SWAP_AFTER_HYST: assert property (FILM_MODE != mode_d_reg |-> evals_reg >= 4'h2)
        else $error("mode swap too early");
    AST_FIELD_RATE: assert property (!FIELD_END |=> $stable(FILM_MODE) && $stable(FILM_TYPE)
        && $stable(FIELD_MOTION) && $stable(GLOBAL_MOTION)) else $error("output moved mid field");
    AST_TYPE_IN_FILM: assert property ($changed(FILM_TYPE) |-> $past(FILM_MODE))
        else $error("type moved outside film mode");
    AST_PHASE_TIMING: assert property ($changed(FILM_PHASE) |->
        $past(FIELD_END, 2) || $past(REG_WR) || $past(REG_WR, 2)) else $error("phase moved at odd time");
endmodule // fmd_sva

bind fmd_top fmd_sva fmd_sva_i (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FIELD_START(FIELD_START),
    .FIELD_END(FIELD_END), .FIELD_B(FIELD_B), .VEC_VALID(VEC_VALID), .VEC_X(VEC_X), .VEC_Y(VEC_Y),
    .DIFF_VALID(DIFF_VALID), .DIFF_VALUE(DIFF_VALUE), .FILM_MODE(FILM_MODE), .FILM_PHASE(FILM_PHASE),
    .FILM_TYPE(FILM_TYPE), .GLOBAL_MOTION(GLOBAL_MOTION), .FIELD_MOTION(FIELD_MOTION));

// ===== tb/fmd_me_model.sv
// Motion estimator stand-in: sends one field of identical block samples.
// Assumes the detector samples on the rising edge; changes come 1 ns after it.
`timescale 1ns/1ns

module fmd_me_model (
    input wire clk,
    output reg f_start = 1'b0,
    output reg f_end = 1'b0,
    output reg f_b = 1'b0,
    output reg v_ok = 1'b0,
    output reg [7:0] v_x = 8'h00,
    output reg [7:0] v_y = 8'h00,
    output reg d_ok = 1'b0,
    output reg [7:0] d_val = 8'h00
);
    ////////////////////////////////////////
    // Start, n samples, end, then a spare cycle for the lagging phase
    task send(input [8:0] n, input [7:0] x, input [7:0] y, input [7:0] d, input b);
        integer i;
        begin
            @(posedge clk) #1;
            f_start = 1'b1;
            f_b = b;
            for (i = 0; i < n; i = i + 1) begin
                @(posedge clk) #1;
                f_start = 1'b0;
                {v_ok, v_x, v_y, d_ok, d_val} = {1'b1, x, y, 1'b1, d};
            end
            @(posedge clk) #1;
            f_start = 1'b0;
            // Idle buses show the inverse of the last sample
            {v_ok, v_x, v_y, d_ok, d_val} = {1'b0, ~x, ~y, 1'b0, ~d};
            f_end = 1'b1;
            @(posedge clk) #1;
            f_end = 1'b0;
            @(posedge clk) #1;
        end
    endtask
endmodule // fmd_me_model

// ===== tb/test_film_mode_motion_detector.sv
// Bench for the film mode detector: a table of one-field cases, then sequences.
// Assumes fmd_top, its checker and the estimator model are compiled first.
`timescale 1ns/1ns

module test_film_mode_motion_detector;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [7:0] wdata = 8'h00;
    reg [7:0] got;
    wire [7:0] rdata, vx, vy, dval;
    wire fs, fe, fb, vv, dv, film, phase, ftype, gmot, fmot;
    integer n_errors = 0;
    integer total_checks = 0;
    integer i;
    // Ctrl, scale, film threshold, source, blocks, x, y, diff, expected motion
    reg [71:0] rows [0:14] = '{72'h00007f00010800ff00, 72'h00007f00010900ff01, 72'h00007f0001f700ff01,
        72'h09407f0001090aff00, 72'h00407f0001090aff01, 72'h00807f00040800ff00, 72'h00807f00030b00ff01,
        72'h00c07f00080800ff00, 72'h00c07f00050d00ff01, 72'h00037f00040800ff00, 72'h00cf0000010900ff01,
        72'h00cf0100010900ff00, 72'h00007f100164001101, 72'h00007f100164001000, 72'h00007ff0016400f101};

    always #2 clk = ~clk;

    fmd_top fmd_top_i (.CORE_CLK(clk), .ARST_N(arst_n), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .FIELD_START(fs), .FIELD_END(fe), .FIELD_B(fb),
        .VEC_VALID(vv), .VEC_X(vx), .VEC_Y(vy), .DIFF_VALID(dv), .DIFF_VALUE(dval), .FILM_MODE(film),
        .FILM_PHASE(phase), .FILM_TYPE(ftype), .GLOBAL_MOTION(gmot), .FIELD_MOTION(fmot));
    fmd_me_model fmd_me_model_i (.clk(clk), .f_start(fs), .f_end(fe), .f_b(fb), .v_ok(vv), .v_x(vx),
        .v_y(vy), .d_ok(dv), .d_val(dval));

    ////////////////////////////////////////
    task chk(input [7:0] g, input [7:0] e);
        begin
            total_checks = total_checks + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wr_reg(input [7:0] a, input [7:0] d);
        begin
            @(posedge clk) #1;
            {wr, addr, wdata} = {1'b1, a, d};
            @(posedge clk) #1;
            wr = 1'b0;
        end
    endtask
    task rd_reg(input [7:0] a, output [7:0] d);
        begin
            @(posedge clk) #1;
            {rd, addr} = {1'b1, a};
            @(posedge clk) #1;
            rd = 1'b0;
            d = rdata;
        end
    endtask
    task fld(input [8:0] n, input [7:0] x, input b);
        fmd_me_model_i.send(n, x, 8'h00, 8'hff, b);
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d, mismatches %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    initial begin
        repeat (10000) @(posedge clk);
        n_errors = n_errors + 1;
        tally_and_finish;
    end

    initial begin
        repeat (10) @(posedge clk);
        #1;
        arst_n = 1'b1;
        chk({film, phase, ftype, gmot, fmot}, 8'h00);
        wr_reg(8'h7e, 8'hff);
        rd_reg(8'h4b, got);
        chk(got, 8'h00);
        rd_reg(8'h7e, got);
        chk(got, 8'h00);
        wr_reg(8'h4f, 8'h0f);
        for (i = 0; i < 15; i = i + 1) begin
            wr_reg(8'h4b, rows[i][71:64]);
            wr_reg(8'h4d, rows[i][63:56]);
            wr_reg(8'h4e, rows[i][55:48]);
            wr_reg(8'h59, rows[i][47:40]);
            fmd_me_model_i.send({1'b0, rows[i][39:32]}, rows[i][31:24], rows[i][23:16], rows[i][15:8], 1'b0);
            chk(fmot, rows[i][7:0]);
        end
        wr_reg(8'h59, 8'h00);
        fld(9'h028, 8'h09, 1'b0);
        rd_reg(8'h7e, got);
        chk(got, 8'h22);
        fld(9'h12c, 8'h09, 1'b0);
        rd_reg(8'h7e, got);
        chk(got, 8'h2f);
        wr_reg(8'h4d, 8'h10);
        wr_reg(8'h4e, 8'h01);
        wr_reg(8'h4f, 8'h01);
        fld(9'h001, 8'h14, 1'b0);
        chk(fmot, 8'h01);
        repeat (6) fld(9'h000, 8'h00, 1'b0);
        for (i = 0; i < 4; i = i + 1) begin
            fld(9'h001, i[0] ? 8'h00 : 8'h64, 1'b0);
            chk(film, i == 3);
        end
        fld(9'h001, 8'h64, 1'b1);
        chk(phase, 8'h01);
        rd_reg(8'h7e, got);
        chk(got, 8'he0);
        fld(9'h001, 8'h14, 1'b0);
        chk(fmot, 8'h00);
        wr_reg(8'h4b, 8'h80);
        rd_reg(8'h7e, got);
        chk(got, 8'ha0);
        chk(phase, 8'h00);
        fld(9'h000, 8'h00, 1'b0);
        chk(ftype, 8'h01);
        for (i = 0; i < 5; i = i + 1) begin
            fld(9'h001, 8'h64, 1'b0);
            chk(film, i < 4);
        end
        for (i = 0; i < 32; i = i + 1) begin
            fld(9'h000, 8'h00, 1'b0);
            chk(gmot, i < 31);
        end
        // Mid-run reset clears outputs, read data and the phase inversion
        chk(phase, 8'h01);
        arst_n = 1'b0;
        #1;
        chk({film, phase, ftype, gmot, fmot}, 8'h00);
        chk(rdata, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        arst_n = 1'b1;
        rd_reg(8'h7e, got);
        chk(got, 8'h00);
        tally_and_finish;
    end
endmodule // test_film_mode_motion_detector
